// ---- rtl/dcl_defines.vh ----
`ifndef DCL_DEFINES_VH
`define DCL_DEFINES_VH

// Memory mode encoding
`define DCL_MODE_LPDDR      2'h0
`define DCL_MODE_DDR2       2'h1
`define DCL_MODE_DDR3       2'h2
`define DCL_MODE_LEGACY_DDR 2'h3

// DLL relock wait in ddr_clock cycles
`define DCL_DLL_LOCK_CYCLES 9000

// Frequency limits in MHz and rate limit in MT/s
`define DCL_DDR2_MIN_MHZ    10'h07d
`define DCL_MAX_MHZ         10'h1c2
`define DCL_MAX_MTS         11'h384

// Latency constants
`define DCL_LPDDR_WL        5'h01
`define DCL_DDR2_AL_MAX     3'h5

// Burst length encodings
`define DCL_BL2             5'h02
`define DCL_BL4             5'h04
`define DCL_BL8             5'h08
`define DCL_BL16            5'h10

// DDR3 additive latency selections
`define DCL_DDR3_AL_ZERO    3'h0
`define DCL_DDR3_AL_CLM1    3'h1
`define DCL_DDR3_AL_CLM2    3'h2

`endif

// ---- rtl/dcl_sync.v ----
`timescale 1ns/1ps
`include "dcl_defines.vh"

module dcl_sync #(
  parameter WIDTH = 1
) (
  input  wire             clk,
  input  wire             reset_n,
  input  wire [WIDTH-1:0] asyncIn,
  output wire [WIDTH-1:0] syncOut
);

  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : gSync
      reg stage1_reg;
      reg stage2_reg;
      always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          stage1_reg <= 1'b0;
          stage2_reg <= 1'b0;
        end else begin
          stage1_reg <= asyncIn[i];
          stage2_reg <= stage1_reg;
        end
      end
      assign syncOut[i] = stage2_reg;
    end
  endgenerate

endmodule // dcl_sync

// ---- rtl/dcl_latency_calc.v ----
`timescale 1ns/1ps
`include "dcl_defines.vh"

module dcl_latency_calc (
  input  wire [1:0] memMode,
  input  wire [3:0] casLatency,
  input  wire [3:0] casWriteLatency,
  input  wire [2:0] additiveSel,
  input  wire [1:0] burstSel,
  output reg  [4:0] readLatency,
  output reg  [4:0] writeLatency,
  output reg  [3:0] additiveLatency,
  output reg  [4:0] burstLength,
  output reg        burstChop,
  output reg        configError
);

  always @* begin
    readLatency     = 5'h00;
    writeLatency    = 5'h00;
    additiveLatency = 4'h0;
    burstLength     = `DCL_BL8;
    burstChop       = 1'b0;
    configError     = 1'b0;
    case (memMode)
      `DCL_MODE_LPDDR: begin
        readLatency  = {1'b0, casLatency}; // RL6
        writeLatency = `DCL_LPDDR_WL; // RL6
        case (burstSel) // RL9
          2'h0:    burstLength = `DCL_BL2;
          2'h1:    burstLength = `DCL_BL4;
          2'h2:    burstLength = `DCL_BL8;
          default: burstLength = `DCL_BL16;
        endcase
      end
      `DCL_MODE_DDR2: begin
        if (additiveSel > `DCL_DDR2_AL_MAX) begin
          configError = 1'b1; // RL7
        end else begin
          additiveLatency = {1'b0, additiveSel}; // RL7
        end
        readLatency  = {1'b0, additiveLatency} + {1'b0, casLatency}; // RL7
        writeLatency = readLatency - 5'h01; // RL7
        case (burstSel) // RL9
          2'h0:    burstLength = `DCL_BL4;
          2'h1:    burstLength = `DCL_BL8;
          default: configError = 1'b1;
        endcase
      end
      `DCL_MODE_DDR3: begin
        case (additiveSel) // RL8
          `DCL_DDR3_AL_ZERO: additiveLatency = 4'h0;
          `DCL_DDR3_AL_CLM1: additiveLatency = casLatency - 4'h1;
          `DCL_DDR3_AL_CLM2: additiveLatency = casLatency - 4'h2;
          default:           configError = 1'b1;
        endcase
        readLatency  = {1'b0, additiveLatency} + {1'b0, casLatency}; // RL8
        writeLatency = {1'b0, additiveLatency} + {1'b0, casWriteLatency}; // RL8
        case (burstSel) // RL9
          2'h0: begin
            burstLength = `DCL_BL4;
            burstChop   = 1'b1;
          end
          2'h1:    burstLength = `DCL_BL8;
          default: configError = 1'b1;
        endcase
      end
      default: configError = 1'b1; // RL15
    endcase
  end

endmodule // dcl_latency_calc

// ---- rtl/dcl_clock_latency_top.v ----
// Operation
// RL1 - Hold DLL reset during clock change; after release wait 9000 ddr_clock cycles.
// RL2 - One ddr_clock feeds both controllers; first generator default, second selectable.
// RL3 - Programmed ddr_clock stays within mode limits; DDR2 at least 125 MHz.
// RL4 - Re-init without frequency change needs no clock generator reprogramming.
// RL5 - Frequency change without content keep repeats the post-reset sequence.
// RL6 - LPDDR: read latency equals CAS latency, no additive, write latency one.
// RL7 - DDR2: read latency AL plus CL, write one less; AL zero to five.
// RL8 - DDR3: read AL plus CL, write AL plus CWL; AL 0, CL-1, CL-2.
// RL9 - Bursts: LPDDR 2/4/8/16, DDR2 4/8, DDR3 8 with chop 4.
// RL10 - At 450 MHz ddr_clock the transfer rate is capped at 900 MT/s.
// RL11 - DDR3 mode drives the memory active-low reset; other modes have none.
// RL12 - DDR3 calibration is started by long or short ZQ commands.
// RL13 - No write or read leveling; single DRAM chip only.
// RL14 - No DDR2 off-chip driver calibration; drive strength by programming only.
// RL15 - Only LPDDR, DDR2 and DDR3 modes; original DDR rejected.
// RL16 - Order: clock generator, then physical interface, then controller init.
// RL17 - Asynchronous clocks may add latency; crossing depends on the clock ratio.
// RL18 - Content-keeping frequency change wraps DLL relock in self-refresh entry and exit; here relock never touches self-refresh, left to software.
// RL19 - DDR3: long ZQ at initialization and after every self-refresh exit.
// RL20 - Memory commands blocked during DLL reset and the relock wait.
`timescale 1ns/1ps
`include "dcl_defines.vh"

module dcl_clock_latency_top #(
  parameter [13:0] LOCK_DDR_CYCLES = `DCL_DLL_LOCK_CYCLES
) (
  input  wire        clk,
  input  wire        reset_n,
  input  wire        ddrClockIn,
  input  wire        dllResetRequest,
  input  wire        clockSourceSelect,
  input  wire [1:0]  memMode,
  input  wire [3:0]  casLatency,
  input  wire [3:0]  casWriteLatency,
  input  wire [2:0]  additiveSel,
  input  wire [1:0]  burstSel,
  input  wire [9:0]  ddrClockMhz,
  input  wire        selfRefreshExit,
  input  wire        zqShortRequest,
  input  wire        commandRequest,
  output reg         dllResetOut,
  output reg         clockSelectOut,
  output reg  [4:0]  readLatency,
  output reg  [4:0]  writeLatency,
  output reg  [3:0]  additiveLatency,
  output reg  [4:0]  burstLength,
  output reg         burstChop,
  output reg         configError,
  output reg         freqError,
  output reg  [10:0] transferRateMts,
  output reg         rateClamped,
  output reg         memResetN,
  output reg         memResetDriveEn,
  output reg         zqLongCmd,
  output reg         zqShortCmd,
  output reg         commandGrant,
  output reg         commandBlocked,
  output reg         lockBusy,
  output reg         ready
);

  localparam [4:0] ST_IDLE      = 5'h01;
  localparam [4:0] ST_DLL_RESET = 5'h02;
  localparam [4:0] ST_LOCK_WAIT = 5'h04;
  localparam [4:0] ST_ZQ_LONG   = 5'h08;
  localparam [4:0] ST_READY     = 5'h10;

  wire        ddrClkSync;
  wire [4:0]  calcRead;
  wire [4:0]  calcWrite;
  wire [3:0]  calcAdditive;
  wire [4:0]  calcBurst;
  wire        calcChop;
  wire        calcError;
  wire        ddrEdge;
  wire        isDdr3;
  wire [10:0] rawRate;

  reg         ddrClkPrev_reg;
  reg  [4:0]  state_reg;
  reg  [4:0]  state_next;
  reg  [13:0] lockCount_reg;
  reg  [13:0] lockCount_next;
  reg         clockSelect_next;
  reg         memReset_next;
  reg         zqShort_next;
  reg         grant_next;

  // ddr_clock is only observed, so it crosses like any pin
  dcl_sync #(
    .WIDTH (1)
  ) uDdrClkSync (
    .clk     (clk),
    .reset_n (reset_n),
    .asyncIn (ddrClockIn),
    .syncOut (ddrClkSync)
  );

  dcl_latency_calc uLatency (
    .memMode         (memMode),
    .casLatency      (casLatency),
    .casWriteLatency (casWriteLatency),
    .additiveSel     (additiveSel),
    .burstSel        (burstSel),
    .readLatency     (calcRead),
    .writeLatency    (calcWrite),
    .additiveLatency (calcAdditive),
    .burstLength     (calcBurst),
    .burstChop       (calcChop),
    .configError     (calcError)
  );

  assign ddrEdge = ddrClkSync & ~ddrClkPrev_reg; // RL17
  assign isDdr3  = (memMode == `DCL_MODE_DDR3);
  // Two transfers per ddr_clock cycle
  assign rawRate = {ddrClockMhz, 1'b0};

  always @* begin
    state_next     = state_reg;
    lockCount_next = lockCount_reg;
    if (dllResetRequest) begin
      state_next     = ST_DLL_RESET; // RL1
      lockCount_next = 14'h0000;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          state_next = ST_IDLE;
        end
        ST_DLL_RESET: begin
          state_next     = ST_LOCK_WAIT; // RL1
          lockCount_next = 14'h0000;
        end
        ST_LOCK_WAIT: begin
          if (ddrEdge) begin
            if (lockCount_reg == LOCK_DDR_CYCLES - 14'h0001) begin // RL1
              state_next = isDdr3 ? ST_ZQ_LONG : ST_READY; // RL19
            end else begin
              lockCount_next = lockCount_reg + 14'h0001;
            end
          end
        end
        ST_ZQ_LONG: begin
          state_next = ST_READY;
        end
        ST_READY: begin
          // Relock is never chained here; software owns self-refresh entry
          if (selfRefreshExit && isDdr3) begin
            state_next = ST_ZQ_LONG; // RL19
          end
        end
        default: begin
          state_next = ST_IDLE;
        end
      endcase
    end
  end

  always @* begin
    // Source may only move while the DLL is held in reset
    clockSelect_next = clockSelectOut;
    if (dllResetRequest) begin
      clockSelect_next = clockSourceSelect; // RL2
    end
    memReset_next = memResetN;
    if (!isDdr3) begin
      memReset_next = 1'b1; // RL11
    end else if (state_reg == ST_LOCK_WAIT && state_next != ST_LOCK_WAIT) begin
      memReset_next = 1'b1; // RL11
    end
    zqShort_next = (state_reg == ST_READY) && (state_next == ST_READY) &&
                   isDdr3 && zqShortRequest; // RL12
    grant_next   = (state_next == ST_READY) && commandRequest &&
                   !zqShort_next && !calcError; // RL20
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ddrClkPrev_reg <= 1'b0;
      state_reg      <= ST_IDLE;
      lockCount_reg  <= 14'h0000;
    end else begin
      ddrClkPrev_reg <= ddrClkSync;
      state_reg      <= state_next;
      lockCount_reg  <= lockCount_next;
    end
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      dllResetOut     <= 1'b0;
      clockSelectOut  <= 1'b0;
      memResetN       <= 1'b0;
      memResetDriveEn <= 1'b0;
      zqLongCmd       <= 1'b0;
      zqShortCmd      <= 1'b0;
      commandGrant    <= 1'b0;
      commandBlocked  <= 1'b1;
      lockBusy        <= 1'b0;
      ready           <= 1'b0;
    end else begin
      dllResetOut     <= dllResetRequest; // RL1
      clockSelectOut  <= clockSelect_next; // RL2
      memResetN       <= memReset_next; // RL11
      memResetDriveEn <= isDdr3; // RL11
      zqLongCmd       <= (state_next == ST_ZQ_LONG); // RL12
      zqShortCmd      <= zqShort_next; // RL12
      commandGrant    <= grant_next; // RL20
      commandBlocked  <= (state_next != ST_READY); // RL20
      lockBusy        <= (state_next == ST_DLL_RESET) || (state_next == ST_LOCK_WAIT);
      ready           <= (state_next == ST_READY);
    end
  end

  // No leveling or driver calibration; latency decode is purely programmed
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      readLatency     <= 5'h00;
      writeLatency    <= 5'h00;
      additiveLatency <= 4'h0;
      burstLength     <= `DCL_BL8;
      burstChop       <= 1'b0;
      configError     <= 1'b0;
    end else begin
      readLatency     <= calcRead; // RL6
      writeLatency    <= calcWrite; // RL7
      additiveLatency <= calcAdditive; // RL8
      burstLength     <= calcBurst; // RL9
      burstChop       <= calcChop; // RL9 RL13 RL14
      configError     <= calcError; // RL15
    end
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      freqError       <= 1'b0;
      transferRateMts <= 11'h000;
      rateClamped     <= 1'b0;
    end else begin
      // Flag only; the device cannot refuse a clock it is given
      freqError <= (ddrClockMhz > `DCL_MAX_MHZ) ||
                   ((memMode == `DCL_MODE_DDR2) && (ddrClockMhz < `DCL_DDR2_MIN_MHZ)); // RL3
      if (rawRate > `DCL_MAX_MTS) begin
        transferRateMts <= `DCL_MAX_MTS; // RL10
        rateClamped     <= 1'b1; // RL10
      end else begin
        transferRateMts <= rawRate;
        rateClamped     <= 1'b0;
      end
    end
  end

endmodule // dcl_clock_latency_top

// ---- test/dcl_ddr_clk_model.sv ----
`timescale 1ns/1ps
module dcl_ddr_clk_model #(
  parameter HALF_NS = 80
) (
  input  wire run,
  output reg  ddrClk
);
  initial ddrClk = 1'b0;
  // Low while stopped, so a clock change adds no stray edges to a relock count
  always begin
    wait (run);
    #(HALF_NS) ddrClk = 1'b1;
    #(HALF_NS) ddrClk = 1'b0;
  end
endmodule // dcl_ddr_clk_model

// ---- test/dcl_clock_latency_monitor.sv ----
`timescale 1ns/1ps
`include "dcl_defines.vh"
module dcl_clock_latency_monitor (
  input wire        clk,
  input wire        reset_n,
  input wire        dllResetRequest,
  input wire [1:0]  memMode,
  input wire [3:0]  casLatency,
  input wire [2:0]  additiveSel,
  input wire [1:0]  burstSel,
  input wire [9:0]  ddrClockMhz,
  input wire        selfRefreshExit,
  input wire        zqShortRequest,
  input wire        dllResetOut,
  input wire [4:0]  readLatency,
  input wire [4:0]  writeLatency,
  input wire [10:0] transferRateMts,
  input wire        rateClamped,
  input wire        zqLongCmd,
  input wire        zqShortCmd,
  input wire        commandGrant,
  input wire        lockBusy,
  input wire        ready
);
  wire [4:0]  sumLat   = {2'h0, additiveSel} + {1'b0, casLatency};
  wire        clampExp = ddrClockMhz > `DCL_MAX_MHZ;
  wire [10:0] rateExp  = clampExp ? `DCL_MAX_MTS : {ddrClockMhz, 1'b0};
  wire        ddr3     = memMode == `DCL_MODE_DDR3;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  chk_dll_echo: assert property (
    dllResetRequest |=> dllResetOut && lockBusy && !ready) else $error("dll echo");
  chk_dll_hold: assert property (
    $fell(dllResetRequest) |-> lockBusy [*8]) else $error("relock cut short");
  chk_busy_nogrant: assert property (
    lockBusy && $past(lockBusy) |-> !commandGrant) else $error("grant while busy");
  chk_lpddr_lat: assert property (
    memMode == `DCL_MODE_LPDDR && additiveSel == 3'h0 |=>
    readLatency == {1'b0, $past(casLatency)} && writeLatency == `DCL_LPDDR_WL)
    else $error("lpddr latency");
  chk_ddr2_lat: assert property (
    memMode == `DCL_MODE_DDR2 && additiveSel <= `DCL_DDR2_AL_MAX && !burstSel[1] |=>
    readLatency == $past(sumLat) && writeLatency == $past(sumLat) - 5'h01)
    else $error("ddr2 latency");
  chk_rate_cap: assert property (
    1'b1 |=> transferRateMts == $past(rateExp) && rateClamped == $past(clampExp))
    else $error("rate cap");
  chk_zq_short: assert property (
    zqShortRequest && ready && ddr3 && !dllResetRequest && !selfRefreshExit |=>
    zqShortCmd && !commandGrant) else $error("zq short");
  chk_sr_zq: assert property (
    selfRefreshExit && ready && ddr3 && !dllResetRequest |=> zqLongCmd && !ready ##1 ready)
    else $error("zq long after exit");
  cov_zq_long: cover property (zqLongCmd);
  cov_clamp: cover property (rateClamped);
  cov_grant: cover property (commandGrant);
endmodule // dcl_clock_latency_monitor

bind dcl_clock_latency_top dcl_clock_latency_monitor dcl_clock_latency_monitor_inst (.*);

// ---- test/tb.sv ----
`timescale 1ns/1ps
module tb;
  typedef struct {int k; int due; logic [15:0] v;} dcl_note_t;
  logic       clk = 1'b0, reset_n = 1'b0, dllResetRequest = 1'b0, clockSourceSelect = 1'b0;
  logic       clkRun = 1'b0, selfRefreshExit = 1'b0, zqShortRequest = 1'b0, commandRequest = 1'b0;
  logic [1:0] memMode = 2'h2, burstSel = 2'h1;
  logic [3:0] casLatency = 4'h6, casWriteLatency = 4'h5;
  logic [2:0] additiveSel = 3'h0;
  logic [9:0] ddrClockMhz = 10'h190;
  wire        ddrClockIn, dllResetOut, clockSelectOut, burstChop, configError, freqError, ready;
  wire        rateClamped, memResetN, memResetDriveEn, zqLongCmd, zqShortCmd, commandGrant;
  wire        commandBlocked, lockBusy;
  wire [4:0]  readLatency, writeLatency, burstLength;
  wire [3:0]  additiveLatency;
  wire [10:0] transferRateMts;
  int         failCount = 0, comparisons = 0, cyc = 0, m, cl, al, bs, mhz, alv, rl, n, zq;
  int         bnd [4] = '{124, 125, 450, 451};
  dcl_note_t  q[$], cur;

  dcl_clock_latency_top #(.LOCK_DDR_CYCLES(14'h8)) dcl_clock_latency_top_inst (.*);
  dcl_ddr_clk_model dcl_ddr_clk_model_inst (.run(clkRun), .ddrClk(ddrClockIn));

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failCount++;
      $display("CHECK FAILED %s expected %0h seen %0h", name, exp, seen);
    end
  endtask

  task automatic note(input int k, input logic [15:0] v, input int lag);
    q.push_back('{k, cyc + lag, v});
  endtask

  task automatic conclude;
    $display("comparisons %0d mismatches %0d", comparisons, failCount);
    if (failCount == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  always #5 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;

  // Notes are due in issue order, so ripe notes always sit at the front of the queue
  always @(posedge clk) begin
    #1;
    while (q.size() > 0 && q[0].due <= cyc) begin
      cur = q.pop_front();
      case (cur.k)
        0: check("latencies", {2'h0, readLatency, writeLatency, additiveLatency}, cur.v);
        1: check("burst", {10'h0, burstChop, burstLength}, cur.v);
        2: check("configError", {15'h0, configError}, cur.v);
        3: check("rate", {3'h0, transferRateMts, rateClamped, freqError}, cur.v);
        4: check("clockSelectOut", {15'h0, clockSelectOut}, cur.v);
        default: check("cmdStatus", {12'h0, commandGrant, zqShortCmd, zqLongCmd, ready}, cur.v);
      endcase
    end
  end

  task automatic dllSeq(input int md, input logic src);
    @(posedge clk);
    memMode <= 2'(md);
    dllResetRequest <= 1'b1;
    clockSourceSelect <= src;
    clkRun <= 1'b0;
    note(4, src, 2);
    note(5, 0, 2);
    repeat (3) @(posedge clk);
    dllResetRequest <= 1'b0;
    clkRun <= 1'b1;
    zq = 0;
    for (n = 0; n < 200 && ready !== 1'b1; n++) begin
      @(negedge clk);
      if (zqLongCmd === 1'b1) zq = 1;
    end
    clkRun <= 1'b0;
    check("relockCycles", 16'(n >= 115 && n <= 135), 16'h1);
    check("zqLongAtInit", 16'(zq), 16'(md == 2));
    check("memReset", {14'h0, memResetDriveEn, memResetN}, {14'h0, 1'(md == 2), 1'b1});
    check("commandBlocked", {15'h0, commandBlocked}, 16'h0);
  endtask

  initial begin
    void'($urandom(1));
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    dllSeq(0, 1'b1);
    dllSeq(2, 1'b0);
    @(posedge clk);
    clockSourceSelect <= 1'b1;
    commandRequest <= 1'b1;
    note(4, 0, 2);
    note(5, 16'h9, 2);
    @(posedge clk);
    zqShortRequest <= 1'b1;
    note(5, 16'h5, 2);
    @(posedge clk);
    zqShortRequest <= 1'b0;
    commandRequest <= 1'b0;
    selfRefreshExit <= 1'b1;
    note(5, 16'h2, 2);
    @(posedge clk);
    selfRefreshExit <= 1'b0;
    commandRequest <= 1'b1;
    note(5, 16'h9, 2);
    dllSeq(2, 1'b1);
    @(posedge clk);
    memMode <= 2'h3;
    note(5, 16'h9, 1);
    note(2, 1, 2);
    note(5, 16'h1, 3);
    repeat (3) @(posedge clk);
    commandRequest <= 1'b0;
    for (int i = 0; i < 40; i++) begin
      @(posedge clk);
      m = $urandom % 4;
      cl = 3 + $urandom % 6;
      al = m == 0 ? 0 : $urandom % 8;
      bs = $urandom % 4;
      mhz = i < 4 ? bnd[i] : 60 + $urandom % 500;
      if (i < 4) m = 1;
      memMode <= 2'(m);
      casLatency <= 4'(cl);
      casWriteLatency <= 4'(cl - 1);
      additiveSel <= 3'(al);
      burstSel <= 2'(bs);
      ddrClockMhz <= 10'(mhz);
      n = m == 3 || (m == 1 && (al > 5 || bs > 1)) || (m == 2 && (al > 2 || bs > 1));
      alv = m == 1 ? al : (m == 2 && al != 0) ? cl - al : 0;
      rl = alv + cl;
      note(2, 16'(n), 2);
      note(3, {11'(mhz > 450 ? 900 : 2 * mhz), 1'(mhz > 450), 1'(mhz > 450 || (m == 1 && mhz < 125))}, 2);
      if (n == 0) begin
        note(0, {5'(rl), 5'(m == 0 ? 1 : m == 1 ? rl - 1 : alv + cl - 1), 4'(alv)}, 2);
        note(1, {1'(m == 2 && bs == 0), 5'(m == 2 ? (bs == 1 ? 8 : 4) : (m == 1 ? 4 : 2) << bs)}, 2);
      end
      @(posedge clk);
    end
    repeat (2) @(posedge clk);
    conclude;
  end

  initial begin
    #50000;
    failCount++;
    $display("watchdog expired");
    conclude;
  end
endmodule // tb
